// ==== rtl/ppss_pkg.sv ====
// Package: register map, field layout and types of the port power source select block
package ppss_pkg;
   localparam logic [15:0] PORT2_CFG_ADDR = 16'h3C04;
   localparam logic [15:0] PORT3_CFG_ADDR = 16'h3C08;
   localparam logic [15:0] STATUS_ADDR = 16'h3C10;
   localparam int COMBINED_BIT = 7;
   localparam int DISABLED_BIT = 5;
   localparam int NONREM_BIT = 4;
   localparam logic [7:0] CFG_WMASK = 8'hBF;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [3:0] SEL_OFF = 4'h0;
   localparam logic [3:0] SEL_USB2 = 4'h1;
   localparam logic [3:0] SEL_USB3 = 4'h2;
   localparam logic [3:0] SEL_EITHER = 4'h3;
   localparam logic [3:0] SEL_GPIO = 4'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic combined;
      logic disabled;
      logic non_removable_attached;
      logic power_on;
   } ppss_port_type;
endpackage : ppss_pkg

// ==== rtl/ppss_top.sv ====
// Port power source select registers for downstream ports 2 and 3, with AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Overview of operation
// - Shared-pin bit 7 clear: power enable and over-current use separate pins.
// - Shared-pin bit set: power enable and over-current sense share one pin.
// - Bit 5 marks the port permanently disabled; hub treats it unusable.
// - Bit 4 reports a permanently attached non-removable device.
// - Source select 0000b keeps port power off.
// - Source select 0001b: power follows USB2 port power state.
// - Source select 0010b: power follows USB3 port power state.
// - Source select 0011b: power on if USB2 or USB3 state on.
// - Source select 0100b: power follows designated general-purpose pin.
// - Port 3 register has same four-bit source select field.
module ppss_top
   import ppss_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [15:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [15:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic [1:0] i_usb2_power,
   input wire logic [1:0] i_usb3_power,
   input wire logic [1:0] i_gpio_power,
   output ppss_port_type o_port2,
   output ppss_port_type o_port3
);

   // Select decode shared by both ports; reserved codes fall to off
   function automatic logic power_from_sel(input logic [3:0] sel, input logic u2, input logic u3,
                                           input logic gp);
      logic on;
      on = 1'b0;
      case (sel)
         SEL_USB2: on = u2;
         SEL_USB3: on = u3;
         SEL_EITHER: on = u2 | u3;
         SEL_GPIO: on = gp;
         default: on = 1'b0;
      endcase
      return on;
   endfunction : power_from_sel

   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic [1:0] usb2_meta, usb2_sync, usb3_meta, usb3_sync, gpio_meta, gpio_sync;
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         usb2_meta <= 2'h0;
         usb2_sync <= 2'h0;
         usb3_meta <= 2'h0;
         usb3_sync <= 2'h0;
         gpio_meta <= 2'h0;
         gpio_sync <= 2'h0;
      end else begin
         usb2_meta <= i_usb2_power;
         usb2_sync <= usb2_meta;
         usb3_meta <= i_usb3_power;
         usb3_sync <= usb3_meta;
         gpio_meta <= i_gpio_power;
         gpio_sync <= gpio_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Write path: address and data may arrive in either order
   logic [15:0] aw_addr;
   logic aw_held, w_held;
   logic [7:0] w_byte;
   logic w_lane0;
   logic [7:0] port2_power_source_config, port3_power_source_config;

   wire aw_take = i_awvalid & o_awready;
   wire w_take = i_wvalid & o_wready;
   wire aw_have = aw_held | aw_take;
   wire w_have = w_held | w_take;
   wire [15:0] wr_addr = aw_held ? aw_addr : i_awaddr;
   wire [7:0] wr_byte = w_held ? w_byte : i_wdata[7:0];
   wire wr_lane0 = w_held ? w_lane0 : i_wstrb[0];
   wire wr_fire = aw_have & w_have & ~o_bvalid;
   wire wr_p2 = (wr_addr == PORT2_CFG_ADDR);
   wire wr_p3 = (wr_addr == PORT3_CFG_ADDR);
   wire wr_hit = wr_p2 | wr_p3 | (wr_addr == STATUS_ADDR);
   // Bit 6 is reserved and read-only zero
   wire [7:0] next_p2 = wr_fire & wr_p2 & wr_lane0 ? (wr_byte & CFG_WMASK) : port2_power_source_config;
   wire [7:0] next_p3 = wr_fire & wr_p3 & wr_lane0 ? (wr_byte & CFG_WMASK) : port3_power_source_config;

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 16'h0000;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end else begin
         o_awready <= ~aw_have & ~o_bvalid & ~wr_fire;
         o_wready <= ~w_have & ~o_bvalid & ~wr_fire;
         if (aw_take) begin
            aw_addr <= i_awaddr;
         end
         if (w_take) begin
            w_byte <= i_wdata[7:0];
            w_lane0 <= i_wstrb[0];
         end
         aw_held <= aw_have & ~wr_fire;
         w_held <= w_have & ~wr_fire;
         if (wr_fire) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // Values are meant to be loaded once at configuration; runtime writes take effect at once
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         port2_power_source_config <= CFG_RESET;
         port3_power_source_config <= CFG_RESET;
      end else begin
         port2_power_source_config <= next_p2;
         port3_power_source_config <= next_p3;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Read path; status word shows the live port outputs
   wire [31:0] status_word = {24'h000000, o_port3, o_port2};
   wire ar_take = i_arvalid & o_arready;
   wire [31:0] rd_mux = (i_araddr == PORT2_CFG_ADDR) ? {24'h000000, port2_power_source_config} :
                        (i_araddr == PORT3_CFG_ADDR) ? {24'h000000, port3_power_source_config} :
                        (i_araddr == STATUS_ADDR) ? status_word : 32'h00000000;
   wire rd_hit = (i_araddr == PORT2_CFG_ADDR) | (i_araddr == PORT3_CFG_ADDR) | (i_araddr == STATUS_ADDR);

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= RESP_OKAY;
      end else begin
         o_arready <= ~o_rvalid & ~ar_take;
         if (ar_take) begin
            o_rvalid <= 1'b1;
            o_rdata <= rd_mux;
            o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Port outputs; a disabled port never gets power
   wire p2_on = power_from_sel(port2_power_source_config[3:0], usb2_sync[0], usb3_sync[0], gpio_sync[0]);
   wire p3_on = power_from_sel(port3_power_source_config[3:0], usb2_sync[1], usb3_sync[1], gpio_sync[1]);
   ppss_port_type next_port2, next_port3;
   assign next_port2 = '{combined: port2_power_source_config[COMBINED_BIT],
                         disabled: port2_power_source_config[DISABLED_BIT],
                         non_removable_attached: port2_power_source_config[NONREM_BIT],
                         power_on: p2_on & ~port2_power_source_config[DISABLED_BIT]};
   assign next_port3 = '{combined: port3_power_source_config[COMBINED_BIT],
                         disabled: port3_power_source_config[DISABLED_BIT],
                         non_removable_attached: port3_power_source_config[NONREM_BIT],
                         power_on: p3_on & ~port3_power_source_config[DISABLED_BIT]};

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_port2 <= '0;
         o_port3 <= '0;
      end else begin
         o_port2 <= next_port2;
         o_port3 <= next_port3;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Source code seen on a port that is not disabled
   // Only the low nibble and the disable bit matter; the other flags must not mask the check
   sequence s_usb2_sel2;
      port2_power_source_config[3:0] == SEL_USB2 && !port2_power_source_config[DISABLED_BIT];
   endsequence
   sequence s_usb2_sel3;
      port3_power_source_config[3:0] == SEL_USB2 && !port3_power_source_config[DISABLED_BIT];
   endsequence
   sequence s_usb3_sel2;
      port2_power_source_config[3:0] == SEL_USB3 && !port2_power_source_config[DISABLED_BIT];
   endsequence
   sequence s_usb3_sel3;
      port3_power_source_config[3:0] == SEL_USB3 && !port3_power_source_config[DISABLED_BIT];
   endsequence
   sequence s_either_sel2;
      port2_power_source_config[3:0] == SEL_EITHER && !port2_power_source_config[DISABLED_BIT];
   endsequence
   sequence s_either_sel3;
      port3_power_source_config[3:0] == SEL_EITHER && !port3_power_source_config[DISABLED_BIT];
   endsequence
   sequence s_gpio_sel2;
      port2_power_source_config[3:0] == SEL_GPIO && !port2_power_source_config[DISABLED_BIT];
   endsequence
   sequence s_gpio_sel3;
      port3_power_source_config[3:0] == SEL_GPIO && !port3_power_source_config[DISABLED_BIT];
   endsequence

   // A write that lands: both channels in hand, no response pending, byte lane 0 strobed
   // Bit 6 must read back as zero whatever the master put on the bus
   sequence s_store2;
      wr_fire && wr_p2 && wr_lane0;
   endsequence
   sequence s_store3;
      wr_fire && wr_p3 && wr_lane0;
   endsequence

   // Output flops lag the register by one edge, so each check looks one cycle on with |=>, and the value compares use $past
   // Port 2
   a_off_sel_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
      port2_power_source_config[3:0] == SEL_OFF |=> !o_port2.power_on)
      else $error("port2 powered with select off");
   // Reserved codes are everything above the last defined one
   a_reserved_off2: assert property (@(posedge i_clk) disable iff (!i_nrst)
      port2_power_source_config[3:0] > SEL_GPIO |=> !o_port2.power_on)
      else $error("port2 powered with reserved select");
   a_usb2_follow: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_usb2_sel2 ##0 $stable(port2_power_source_config) |=> o_port2.power_on == $past(usb2_sync[0]))
      else $error("port2 not following usb2 state");
   a_usb3_follow2: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_usb3_sel2 |=> o_port2.power_on == $past(usb3_sync[0]))
      else $error("port2 not following usb3 state");
   a_either_on: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_either_sel2 |=> o_port2.power_on == $past(usb2_sync[0] | usb3_sync[0]))
      else $error("port2 either mode wrong");
   a_gpio_follow2: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_gpio_sel2 |=> o_port2.power_on == $past(gpio_sync[0]))
      else $error("port2 not following gpio");
   a_disabled_dark: assert property (@(posedge i_clk) disable iff (!i_nrst)
      port2_power_source_config[DISABLED_BIT] |=> o_port2.disabled && !o_port2.power_on)
      else $error("disabled port2 powered");
   a_shared_pin2: assert property (@(posedge i_clk) disable iff (!i_nrst)
      1'b1 |=> o_port2.combined == $past(port2_power_source_config[COMBINED_BIT]))
      else $error("port2 combined flag mismatch");
   a_nonrem_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
      1'b1 |=> o_port2.non_removable_attached == $past(port2_power_source_config[NONREM_BIT]))
      else $error("port2 non-removable flag mismatch");
   a_port2_store: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_store2 |=> port2_power_source_config == $past(wr_byte & CFG_WMASK))
      else $error("port2 register missed a write");

   // Port 3 carries the same fields and codes as port 2
   // The port 3 inputs sit in bit 1 of each sync vector
   a_off_sel3: assert property (@(posedge i_clk) disable iff (!i_nrst)
      port3_power_source_config[3:0] == SEL_OFF |=> !o_port3.power_on)
      else $error("port3 powered with select off");
   a_reserved_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
      port3_power_source_config[3:0] > SEL_GPIO |=> !o_port3.power_on)
      else $error("port3 powered with reserved select");
   a_usb2_follow3: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_usb2_sel3 |=> o_port3.power_on == $past(usb2_sync[1]))
      else $error("port3 not following usb2 state");
   a_usb3_follow: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_usb3_sel3 |=> o_port3.power_on == $past(usb3_sync[1]))
      else $error("port3 not following usb3 state");
   a_either_on3: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_either_sel3 |=> o_port3.power_on == $past(usb2_sync[1] | usb3_sync[1]))
      else $error("port3 either mode wrong");
   a_gpio_follow: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_gpio_sel3 |=> o_port3.power_on == $past(gpio_sync[1]))
      else $error("port3 not following gpio");
   a_disabled_dark3: assert property (@(posedge i_clk) disable iff (!i_nrst)
      port3_power_source_config[DISABLED_BIT] |=> o_port3.disabled && !o_port3.power_on)
      else $error("disabled port3 powered");
   a_shared_pin: assert property (@(posedge i_clk) disable iff (!i_nrst)
      1'b1 |=> o_port3.combined == $past(port3_power_source_config[COMBINED_BIT]))
      else $error("port3 combined flag mismatch");
   a_nonrem_flag3: assert property (@(posedge i_clk) disable iff (!i_nrst)
      1'b1 |=> o_port3.non_removable_attached == $past(port3_power_source_config[NONREM_BIT]))
      else $error("port3 non-removable flag mismatch");
   a_port3_store: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_store3 |=> port3_power_source_config == $past(wr_byte & CFG_WMASK))
      else $error("port3 register missed a write");

endmodule : ppss_top

// ==== dv/port_power_source_select_bench.sv ====
// Self-checking bench for the port power source select register block
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module port_power_source_select_bench;
   import ppss_pkg::*;
   logic i_clk = 1'b0, i_nrst = 1'b0;
   logic [15:0] i_awaddr = 16'h0000, i_araddr = 16'h0000, lf = 16'hAA77;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
   logic [31:0] i_wdata = 32'h0, o_rdata, d;
   logic [3:0] i_wstrb = 4'h0;
   logic [1:0] i_usb2_power = 2'h0, i_usb3_power = 2'h0, i_gpio_power = 2'h0, o_bresp, o_rresp, r;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   ppss_port_type o_port2, o_port3, prt;
   logic [7:0] cfg;
   logic [15:0] adr;
   int mismatches = 0, samples_checked = 0;
   ppss_top i_ppss_top (.i_clk(i_clk), .i_nrst(i_nrst), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
      .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
      .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
      .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
      .i_usb2_power(i_usb2_power), .i_usb3_power(i_usb3_power), .i_gpio_power(i_gpio_power),
      .o_port2(o_port2), .o_port3(o_port3));
   always #10 i_clk = ~i_clk;
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   // Disabled ports and reserved codes both leave power off
   function automatic logic exp_pwr(input logic [7:0] c, input logic u2, input logic u3, input logic gp);
      if (c[5]) return 1'b0;
      case (c[3:0])
         SEL_USB2: return u2;
         SEL_USB3: return u3;
         SEL_EITHER: return u2 | u3;
         SEL_GPIO: return gp;
         default: return 1'b0;
      endcase
   endfunction : exp_pwr
   // Handshakes are judged at the falling edge, where ready and valid are settled for the next rise
   task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic [3:0] s, input logic [1:0] er);
      logic ha, hw, pa, pw;
      // One edge between calls, so bready never drops and rises in one time step
      @(posedge i_clk);
      pa = 1'b1;
      pw = 1'b1;
      lf = lfsr_next(lf);
      i_awaddr <= a;
      i_wdata <= {lf, 8'h00, v};
      i_wstrb <= s;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      while (pa || pw) begin
         @(negedge i_clk);
         ha = i_awvalid & o_awready;
         hw = i_wvalid & o_wready;
         @(posedge i_clk);
         if (ha) begin
            i_awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (hw) begin
            i_wvalid <= 1'b0;
            pw = 1'b0;
         end
      end
      do begin
         @(negedge i_clk);
         ha = o_bvalid;
         r = o_bresp;
         @(posedge i_clk);
      end while (!ha);
      i_bready <= 1'b0;
      `CHK("bresp", er, r)
   endtask : wr
   task automatic rd(input logic [15:0] a);
      logic h;
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do begin
         @(negedge i_clk);
         h = o_arready;
         @(posedge i_clk);
      end while (!h);
      i_arvalid <= 1'b0;
      do begin
         @(negedge i_clk);
         h = o_rvalid;
         d = o_rdata;
         r = o_rresp;
         @(posedge i_clk);
      end while (!h);
      i_rready <= 1'b0;
   endtask : rd
   task automatic summarize();
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      rd(PORT2_CFG_ADDR);
      `CHK("cfg2 after reset", 32'h0, d)
      `CHK("port2 after reset", 4'h0, o_port2)
      $display("reset test done");
      // Every select code on both ports, disabled bit on a third of the passes
      for (int k = 0; k < 48; k++) begin
         lf = lfsr_next(lf);
         cfg = lf[7:0];
         cfg[3:0] = 4'((k / 2) % 16);
         cfg[5] = (k % 3 == 0);
         adr = k[0] ? PORT3_CFG_ADDR : PORT2_CFG_ADDR;
         wr(adr, cfg, 4'hF, RESP_OKAY);
         i_usb2_power <= lf[9:8];
         i_usb3_power <= lf[11:10];
         i_gpio_power <= lf[13:12];
         repeat (5) @(negedge i_clk);
         prt = k[0] ? o_port3 : o_port2;
         `CHK("power_on", exp_pwr(cfg, lf[8 + k[0]], lf[10 + k[0]], lf[12 + k[0]]), prt.power_on)
         `CHK("combined", cfg[COMBINED_BIT], prt.combined)
         `CHK("disabled", cfg[DISABLED_BIT], prt.disabled)
         `CHK("non_removable", cfg[NONREM_BIT], prt.non_removable_attached)
         rd(adr);
         `CHK("readback", {24'h0, cfg & CFG_WMASK}, d)
         `CHK("rresp", RESP_OKAY, r)
      end
      $display("select code test done");
      wr(16'h3C20, 8'hFF, 4'hF, RESP_SLVERR);
      wr(adr, 8'h5A, 4'h0, RESP_OKAY);
      rd(adr);
      `CHK("unchanged cfg", {24'h0, cfg & CFG_WMASK}, d)
      rd(16'h3C20);
      `CHK("unmapped rresp", RESP_SLVERR, r)
      `CHK("unmapped rdata", 32'h0, d)
      $display("refusal test done");
      summarize();
   end
endmodule : port_power_source_select_bench
